// *** cpwm_channel.sv ***
// compare channel in pwm mode with apb registers, power states and fault guard
// Behaviour
// RL1: duty buffer writable anytime; copied to active duty only at period match.
// RL2: active duty register is read-only while in pwm mode.
// RL3: zero active duty keeps the output low all period.
// RL4: active duty above period keeps the output high all period.
// RL5: duty equal to period gives low for exactly one count.
// RL6: in sleep the output holds its level and halts, resuming on wake.
// RL7: stop-in-idle bit 13 set makes idle behave like sleep.
// RL8: with bit clear, idle runs only if timer enabled and not idle-stopped.
// RL9: enabled fault inputs keep control of the pin in sleep and idle.
// RL10: mode 110 is pwm, mode 111 is pwm with fault protection.
// RL11: period value N gives N plus one counts per period.
// RL12: period match loads duty, drives high, raises timer flag; low at duty.
// RL13: fault low tristates pin, sets fault flag and compare flag until rearm; here the compare flag clears by write-one-to-clear, not rearm.
// RL14: duty copy happens on the same edge as the timer reset.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "cpwm_defines.svh"
module cpwm_channel
  import cpwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire cpwm_timer_t tmr,
  input  wire cpwm_power_t pwr,
  input  wire logic        fault_input_a,
  output logic             compare_output_pin,
  output logic             compare_output_oe_n,
  output logic             irq
);
  logic [15:0] ctrl_r;
  logic [15:0] duty_buffer_reg_r;
  logic [15:0] active_duty_reg;
  logic [`CPWM_IRQ_W-1:0] irq_stat_r;
  logic [`CPWM_IRQ_W-1:0] irq_mask_r;
  logic [`CPWM_IRQ_W-1:0] irq_set;
  logic [`CPWM_IRQ_W-1:0] irq_clr;
  logic [31:0] rdata_nxt;
  logic [2:0]  compare_mode_field;
  logic        stop_in_idle_bit;
  logic        fault_status_flag;
  logic        pwm_on;
  logic        flt_mode;
  logic        run;
  logic        level;
  logic        period_hit;
  logic        fault_rise;
  logic        wr_en;
  logic        rd_en;
  logic        mode_wr;
  logic        act_wr;
  logic        addr_ok;
  cpwm_state_t state_r;

  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = (m == `CPWM_MODE_PWM) || (m == `CPWM_MODE_PWM_FLT); // RL10
  endfunction : is_pwm

  assign compare_mode_field = ctrl_r[`CPWM_MODE_MSB:`CPWM_MODE_LSB];
  assign stop_in_idle_bit   = ctrl_r[`CPWM_SIDL_BIT];
  assign pwm_on             = is_pwm(compare_mode_field);
  assign flt_mode           = (compare_mode_field == `CPWM_MODE_PWM_FLT); // RL10

  // channel advances only when clocks run and idle rules allow
  always_comb begin
    run = !pwr.sleep; // RL6
    if (pwr.idle) begin
      if (stop_in_idle_bit) begin
        run = 1'b0; // RL7
      end else begin
        run = run && tmr.enabled && !tmr.stop_idle; // RL8
      end
    end
  end

  // apb decode, zero wait states
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign mode_wr = wr_en && (paddr == `CPWM_OFF_CTRL);
  assign act_wr  = wr_en && (paddr == `CPWM_OFF_DUTYACT);

  always_comb begin
    addr_ok = 1'b1;
    if (paddr == `CPWM_OFF_CTRL) begin
      rdata_nxt = {16'h0000, ctrl_r[15:5], fault_status_flag, ctrl_r[3:0]};
    end else if (paddr == `CPWM_OFF_DUTYBUF) begin
      rdata_nxt = {16'h0000, duty_buffer_reg_r};
    end else if (paddr == `CPWM_OFF_DUTYACT) begin
      rdata_nxt = {16'h0000, active_duty_reg};
    end else if (paddr == `CPWM_OFF_STATUS) begin
      rdata_nxt = {29'h00000000, level, run, fault_status_flag};
    end else if (paddr == `CPWM_OFF_IRQ_STAT) begin
      rdata_nxt = {30'h00000000, irq_stat_r};
    end else if (paddr == `CPWM_OFF_IRQ_MASK) begin
      rdata_nxt = {30'h00000000, irq_mask_r};
    end else begin
      rdata_nxt = 32'h00000000;
      addr_ok   = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 16'h0000;
    end else if (mode_wr) begin
      ctrl_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_buffer_reg_r <= 16'h0000;
    end else if (wr_en && paddr == `CPWM_OFF_DUTYBUF) begin
      duty_buffer_reg_r <= pwdata[15:0]; // RL1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= '0;
    end else if (wr_en && paddr == `CPWM_OFF_IRQ_MASK) begin
      irq_mask_r <= pwdata[`CPWM_IRQ_W-1:0];
    end
  end

  // sticky flags: set beats write-one-to-clear
  always_comb begin
    irq_set = '0;
    irq_set[`CPWM_IRQ_TMR_BIT] = period_hit; // RL12
    irq_set[`CPWM_IRQ_CMP_BIT] = fault_rise; // RL13
    irq_clr = (wr_en && paddr == `CPWM_OFF_IRQ_STAT) ? pwdata[`CPWM_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  cpwm_fault_guard u_guard (
    .pclk            (pclk),
    .presetn         (presetn),
    .fault_en        (flt_mode),
    .fault_n         (fault_input_a),
    .rearm           (mode_wr),
    .fault_latched_r (fault_status_flag),
    .fault_rise      (fault_rise)
  );

  cpwm_duty_core u_core (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (run),
    .pwm_on     (pwm_on),
    .tmr        (tmr),
    .duty_buf   (duty_buffer_reg_r),
    .act_wr     (act_wr),
    .act_wdata  (pwdata[15:0]),
    .duty_act_r (active_duty_reg),
    .level_r    (level),
    .period_hit (period_hit)
  );

  // channel state for pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CPWM_ST_OFF;
    end else begin
      case (state_r)
        CPWM_ST_OFF: begin
          if (pwm_on) begin
            state_r <= CPWM_ST_RUN;
          end
        end
        CPWM_ST_RUN: begin
          if (flt_mode && !fault_input_a) begin
            state_r <= CPWM_ST_FAULT; // RL13
          end else if (!pwm_on) begin
            state_r <= CPWM_ST_OFF;
          end
        end
        default: begin
          if (mode_wr && fault_input_a) begin
            state_r <= CPWM_ST_OFF; // RL13
          end
        end
      endcase
    end
  end

  // pin drive: oe_n high releases the pin while faulted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_pin  <= 1'b0;
      compare_output_oe_n <= 1'b0;
    end else begin
      compare_output_pin  <= level;
      compare_output_oe_n <= (flt_mode && !fault_input_a) || fault_status_flag
                             || (state_r == CPWM_ST_FAULT); // RL9 RL13
    end
  end

  sleep_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr.sleep |-> !run) else $error("channel running in sleep"); // RL6
  idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr.idle && stop_in_idle_bit) |-> !run) else $error("channel running in idle"); // RL7
  idle_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pwr.idle && !pwr.sleep && !stop_in_idle_bit) |-> run == (tmr.enabled && !tmr.stop_idle))
    else $error("idle run gating wrong"); // RL8
  period_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_hit |=> irq_stat_r[`CPWM_IRQ_TMR_BIT]) else $error("timer flag not raised"); // RL12
  // multi-step behaviours checked below
  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_answer_s;
    pready ##1 !pready;
  endsequence
  sequence fault_seen_s;
    flt_mode && !fault_input_a;
  endsequence
  sequence fault_flagged_s;
    compare_output_oe_n && fault_status_flag && irq_stat_r[`CPWM_IRQ_CMP_BIT];
  endsequence
  sequence period_start_s;
    period_hit && (duty_buffer_reg_r != `CPWM_DUTY_ZERO);
  endsequence
  sequence pin_rise_s;
    level ##1 compare_output_pin;
  endsequence

  fault_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_seen_s |=> compare_output_oe_n) else $error("fault did not release pin"); // RL9 RL13
  fault_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_rise |=> fault_flagged_s) else $error("fault flags not raised"); // RL13
  fault_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_status_flag && mode_wr && fault_input_a) |=> !fault_status_flag)
    else $error("fault flag not rearmed"); // RL13
  pin_driven_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_input_a && !fault_status_flag && (state_r != CPWM_ST_FAULT)) |=> !compare_output_oe_n)
    else $error("pin released without fault"); // RL9 RL13
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> apb_answer_s) else $error("apb answer not one cycle");
  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  period_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_start_s |=> pin_rise_s) else $error("pin not high at period start"); // RL12
  duty_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && pwm_on && !period_hit && (active_duty_reg != `CPWM_DUTY_ZERO) && (active_duty_reg <= tmr.period)
     && (tmr.count + 16'h0001 == active_duty_reg)) |=> !level)
    else $error("level not low at duty match"); // RL5 RL12
  active_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (act_wr && pwm_on && !period_hit) |=> $stable(active_duty_reg))
    else $error("active duty written in pwm mode"); // RL2
  mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pwm_on |=> !level) else $error("level high outside pwm modes"); // RL10
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((|(irq_stat_r & irq_mask_r)) && (irq_clr == '0)) |=> irq) else $error("irq low with pending flag");
endmodule : cpwm_channel

// *** cpwm_defines.svh ***
// offsets, field positions, reset values and counts for the compare pwm channel
`ifndef CPWM_DEFINES_SVH
`define CPWM_DEFINES_SVH
`define CPWM_OFF_CTRL      12'h000
`define CPWM_OFF_DUTYBUF   12'h004
`define CPWM_OFF_DUTYACT   12'h008
`define CPWM_OFF_STATUS    12'h00C
`define CPWM_OFF_IRQ_STAT  12'h010
`define CPWM_OFF_IRQ_MASK  12'h014
`define CPWM_MODE_LSB      0
`define CPWM_MODE_MSB      2
`define CPWM_FLT_BIT       4
`define CPWM_SIDL_BIT      13
`define CPWM_MODE_PWM      3'h6
`define CPWM_MODE_PWM_FLT  3'h7
`define CPWM_MODE_OFF      3'h0
`define CPWM_DUTY_ZERO     16'h0000
`define CPWM_IRQ_TMR_BIT   0
`define CPWM_IRQ_CMP_BIT   1
`define CPWM_IRQ_W         2
`define CPWM_ADDR_W        12
`endif

// *** cpwm_duty_core.sv ***
// duty double buffer and compare output generator
`include "cpwm_defines.svh"
module cpwm_duty_core
  import cpwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        pwm_on,
  input  wire cpwm_timer_t tmr,
  input  wire logic [15:0] duty_buf,
  input  wire logic        act_wr,
  input  wire logic [15:0] act_wdata,
  output logic [15:0]      duty_act_r,
  output logic             level_r,
  output logic             period_hit
);
  logic        lvl_nxt;
  logic [15:0] eff_duty;

  assign period_hit = run && pwm_on && (tmr.count == tmr.period); // RL11

  // new period uses the freshly loaded duty
  assign eff_duty = period_hit ? duty_buf : duty_act_r; // RL14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_act_r <= `CPWM_DUTY_ZERO;
    end else if (period_hit) begin
      duty_act_r <= duty_buf; // RL1
    end else if (act_wr && !pwm_on) begin
      duty_act_r <= act_wdata; // RL2
    end
  end

  // level for the count that follows this edge
  always_comb begin
    lvl_nxt = level_r;
    if (period_hit) begin
      lvl_nxt = (eff_duty != `CPWM_DUTY_ZERO); // RL3 RL12
    end else if (tmr.count + 16'h0001 == eff_duty) begin
      lvl_nxt = 1'b0; // RL5 RL12
    end
    if (eff_duty > tmr.period) begin
      lvl_nxt = 1'b1; // RL4
    end
    if (eff_duty == `CPWM_DUTY_ZERO) begin
      lvl_nxt = 1'b0; // RL3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 1'b0;
    end else if (!pwm_on) begin
      level_r <= 1'b0;
    end else if (run) begin
      level_r <= lvl_nxt; // RL6
    end
  end

  hold_stopped_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!run && pwm_on) |=> $stable(level_r)) else $error("level moved while halted"); // RL6
  zero_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && pwm_on && eff_duty == `CPWM_DUTY_ZERO) |=> !level_r) else $error("zero duty not low"); // RL3
  full_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && pwm_on && eff_duty > tmr.period) |=> level_r) else $error("full duty not high"); // RL4
  load_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    period_hit |=> duty_act_r == $past(duty_buf)) else $error("duty not loaded at period"); // RL1
  no_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!period_hit && pwm_on) |=> $stable(duty_act_r)) else $error("active duty changed mid period"); // RL2
endmodule : cpwm_duty_core

// *** cpwm_fault_guard.sv ***
// fault input qualifier: drives pin release and fault latch
`include "cpwm_defines.svh"
module cpwm_fault_guard
  import cpwm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fault_en,
  input  wire logic fault_n,
  input  wire logic rearm,
  output logic      fault_latched_r,
  output logic      fault_rise
);
  logic fault_nxt;

  // latch stays until the fault is gone and the mode is rewritten
  always_comb begin
    fault_nxt = fault_latched_r;
    if (fault_en && !fault_n) begin
      fault_nxt = 1'b1; // RL13
    end else if (rearm && fault_n) begin
      fault_nxt = 1'b0; // RL13
    end
  end

  assign fault_rise = fault_nxt && !fault_latched_r;

  // no clock gating here: the guard keeps working in sleep and idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_latched_r <= 1'b0;
    end else begin
      fault_latched_r <= fault_nxt; // RL9
    end
  end

  fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_en && !fault_n) |=> fault_latched_r) else $error("fault not latched"); // RL13
  fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_latched_r && !rearm) |=> fault_latched_r) else $error("fault dropped without rearm"); // RL13
endmodule : cpwm_fault_guard

// *** cpwm_load.sv ***
// external load on the pwm pin, pulled down while the pin is released
module cpwm_load (
  input  wire logic pin,
  input  wire logic oe_n,
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign level = oe_n ? 1'b0 : pin;
endmodule : cpwm_load

// *** cpwm_pkg.sv ***
// types shared by the compare pwm channel
package cpwm_pkg;
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic        enabled;
    logic        stop_idle;
  } cpwm_timer_t;

  typedef struct packed {
    logic sleep;
    logic idle;
  } cpwm_power_t;

  typedef enum logic [1:0] {
    CPWM_ST_OFF,
    CPWM_ST_RUN,
    CPWM_ST_FAULT
  } cpwm_state_t;
endpackage : cpwm_pkg

// *** tb_compare_pwm_duty_power_save.sv ***
// self-checking bench for the compare pwm channel
`include "cpwm_defines.svh"
module tb_compare_pwm_duty_power_save
  import cpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pin, oe_n, irq, flt_n, load_lvl, ten, tsidl, tgo;
  logic [15:0] cnt, per, d;
  logic [15:0] dl [5];
  cpwm_timer_t tmr;
  cpwm_power_t pwr;
  int          error_cnt, compares;

  assign tmr = '{count: cnt, period: per, enabled: ten, stop_idle: tsidl};

  cpwm_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmr(tmr),
    .pwr(pwr), .fault_input_a(flt_n), .compare_output_pin(pin), .compare_output_oe_n(oe_n), .irq(irq));
  cpwm_load load (.pin(pin), .oe_n(oe_n), .level(load_lvl));

  // free-running time base, wraps after the period value
  always @(posedge pclk) begin
    if (tgo) cnt <= (cnt == per) ? 16'h0000 : cnt + 16'h0001;
  end

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic err);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin $display("BAD pready expected 1 seen timeout"); error_cnt++; summarize(); end
    rd = prdata;
    chk("pslverr", pslverr, err);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wper(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin @(posedge pclk); n++; end while (cnt !== per && n < 200);
      if (n >= 200) begin $display("BAD period expected match seen timeout"); error_cnt++; summarize(); end
    end
  endtask : wper

  // model: high cycles in one period for a given duty
  task automatic meas(input logic [15:0] dv);
    logic [31:0] h;
    wper(2);
    h = 0;
    repeat (per + 1) begin @(posedge pclk); h += load_lvl; end
    chk("high cycles", h, (dv == 0) ? 0 : (dv > per) ? per + 1 : dv);
  endtask : meas

  task automatic hold(input string nm);
    logic v;
    repeat (3) @(posedge pclk);
    v = load_lvl;
    repeat (20) begin @(posedge pclk); chk(nm, load_lvl, v); end
  endtask : hold

  initial begin
    repeat (100000) @(posedge pclk);
    $display("BAD watchdog expected end seen hang");
    error_cnt++;
    summarize();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    cnt = 16'h0000; per = 16'h0008; ten = 1'b1; tsidl = 1'b0; tgo = 1'b0; pwr = '0; flt_n = 1'b1;
    error_cnt = 0; compares = 0;
    d = 16'($urandom(32'h744E));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    per <= 16'(8 + $urandom % 8);
    apb(1'b0, `CPWM_OFF_CTRL, 32'h0, 1'b0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b1, `CPWM_OFF_DUTYACT, 32'h5, 1'b0);
    apb(1'b1, `CPWM_OFF_CTRL, 32'h6, 1'b0);
    apb(1'b1, `CPWM_OFF_DUTYACT, 32'h9, 1'b0);
    apb(1'b0, `CPWM_OFF_DUTYACT, 32'h0, 1'b0);
    chk("duty act", rd, 32'h5);
    apb(1'b0, 12'h020, 32'h0, 1'b1);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    apb(1'b1, `CPWM_OFF_DUTYBUF, 32'h3, 1'b0);
    apb(1'b0, `CPWM_OFF_DUTYBUF, 32'h0, 1'b0);
    chk("duty buffer", rd, 32'h3);
    apb(1'b0, `CPWM_OFF_DUTYACT, 32'h0, 1'b0);
    chk("act before match", rd, 32'h5);
    tgo <= 1'b1;
    wper(1);
    apb(1'b0, `CPWM_OFF_DUTYACT, 32'h0, 1'b0);
    chk("act after match", rd, 32'h3);
    apb(1'b0, `CPWM_OFF_IRQ_STAT, 32'h0, 1'b0);
    chk("timer flag", rd[0], 32'h1);
    // irq follows a mask write one edge later
    apb(1'b1, `CPWM_OFF_IRQ_MASK, 32'h1, 1'b0);
    @(posedge pclk);
    chk("irq on", irq, 32'h1);
    apb(1'b1, `CPWM_OFF_IRQ_MASK, 32'h0, 1'b0);
    @(posedge pclk);
    chk("irq masked", irq, 32'h0);
    $display("test double buffer done");
    d = 16'(1 + $urandom % (per - 1));
    dl = '{16'h0000, 16'h0001, per, per + 16'h0001, d};
    for (int m = 6; m < 8; m++) begin
      apb(1'b1, `CPWM_OFF_CTRL, 32'(m), 1'b0);
      foreach (dl[i]) begin
        apb(1'b1, `CPWM_OFF_DUTYBUF, {16'h0000, dl[i]}, 1'b0);
        meas(dl[i]);
      end
    end
    $display("test duty boundaries done");
    apb(1'b1, `CPWM_OFF_CTRL, 32'h6, 1'b0);
    meas(d);
    pwr.sleep <= 1'b1;
    hold("sleep hold");
    apb(1'b0, `CPWM_OFF_STATUS, 32'h0, 1'b0);
    chk("run in sleep", rd[1], 32'h0);
    pwr.sleep <= 1'b0;
    meas(d);
    apb(1'b1, `CPWM_OFF_CTRL, 32'h2006, 1'b0);
    pwr.idle <= 1'b1;
    hold("idle stop hold");
    pwr.idle <= 1'b0;
    apb(1'b1, `CPWM_OFF_CTRL, 32'h6, 1'b0);
    pwr.idle <= 1'b1;
    meas(d);
    tsidl <= 1'b1;
    hold("timer idle hold");
    tsidl <= 1'b0;
    ten <= 1'b0;
    hold("timer off hold");
    ten <= 1'b1;
    pwr.idle <= 1'b0;
    $display("test power states done");
    apb(1'b1, `CPWM_OFF_CTRL, 32'h7, 1'b0);
    apb(1'b1, `CPWM_OFF_IRQ_MASK, 32'h2, 1'b0);
    pwr.sleep <= 1'b1;
    flt_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("oe_n fault", oe_n, 32'h1);
    chk("pin fault", load_lvl, 32'h0);
    chk("irq fault", irq, 32'h1);
    pwr.sleep <= 1'b0;
    apb(1'b0, `CPWM_OFF_CTRL, 32'h0, 1'b0);
    chk("fault flag", rd[4], 32'h1);
    apb(1'b1, `CPWM_OFF_IRQ_STAT, 32'h2, 1'b0);
    chk("irq cleared", irq, 32'h0);
    apb(1'b1, `CPWM_OFF_CTRL, 32'h7, 1'b0);
    chk("oe_n still off", oe_n, 32'h1);
    flt_n <= 1'b1;
    apb(1'b1, `CPWM_OFF_CTRL, 32'h7, 1'b0);
    apb(1'b0, `CPWM_OFF_CTRL, 32'h0, 1'b0);
    chk("fault flag clear", rd[4], 32'h0);
    chk("oe_n rearmed", oe_n, 32'h0);
    meas(d);
    $display("test fault done");
    summarize();
  end
endmodule : tb_compare_pwm_duty_power_save
